// ### logic/socket_regs_pkg.sv
package socket_regs_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [5:0] ID_REVISION_OFFSET      = 6'h00;
	localparam logic [5:0] INTERFACE_STATUS_OFFSET = 6'h01;
	localparam logic [5:0] POWER_CONTROL_OFFSET    = 6'h02;

	// ****************************************
	// Identification fields
	// ****************************************
	localparam logic [1:0] INTERFACE_TYPE_CODE     = 2'h2;
	localparam logic [1:0] EMULATION_RESET         = 2'h0;
	// Revision reset value is arbitrary
	localparam logic [3:0] REVISION_RESET          = 4'h5;
	localparam logic [3:0] LEGACY_REVISION_CODE    = 4'h2;
	localparam int         ID_TYPE_MSB             = 7;
	localparam int         ID_TYPE_LSB             = 6;
	localparam int         ID_EMU_MSB              = 5;
	localparam int         ID_EMU_LSB              = 4;
	localparam int         ID_REV_MSB              = 3;
	localparam int         ID_REV_LSB              = 0;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int         STAT_POWER_BIT          = 6;
	localparam int         STAT_READY_BIT          = 5;
	localparam int         STAT_WP_BIT             = 4;
	localparam int         STAT_DETECT_TWO_BIT     = 3;
	localparam int         STAT_DETECT_ONE_BIT     = 2;

	// ****************************************
	// Power control fields
	// ****************************************
	localparam logic [7:0] POWER_CONTROL_RESET     = 8'h00;
	localparam int         PWR_GATE_BIT            = 7;
	localparam int         PWR_AUTO_BIT            = 5;
	localparam int         PWR_VCC_EN_BIT          = 4;
	localparam int         PWR_VCC_MSB             = 4;
	localparam int         PWR_VCC_LSB             = 3;
	localparam logic [7:0] PWR_LEGACY_MASK         = 8'hB3;
	localparam logic [7:0] PWR_NATIVE_MASK         = 8'h9B;
	localparam logic [1:0] VCC_OFF                 = 2'h0;
	localparam logic [1:0] VCC_OFF_RESERVED        = 2'h1;

	// ****************************************
	// Socket pin vector positions
	// ****************************************
	localparam int         PIN_COUNT               = 8;
	localparam int         PIN_READY               = 0;
	localparam int         PIN_WP                  = 1;
	localparam int         PIN_DETECT_TWO          = 2;
	localparam int         PIN_DETECT_ONE          = 3;
	localparam int         PIN_BATTERY_TWO         = 4;
	localparam int         PIN_BATTERY_ONE         = 5;
	localparam int         PIN_AUDIO               = 6;
	localparam int         PIN_STATUS_CHANGE       = 7;
	localparam logic [7:0] PIN_RESET_VALUE         = 8'h0C;
	localparam logic [7:0] READ_UNMAPPED           = 8'h00;

endpackage : socket_regs_pkg

// ### logic/pin_sync_if.sv
interface pin_sync_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] synced;

	modport owner (output raw, input synced);
	modport sync (input raw, output synced);
endinterface : pin_sync_if

// ### logic/pin_synchroniser.sv
module pin_synchroniser
	import socket_regs_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = PIN_RESET_VALUE
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	pin_sync_if.sync  pins
);

	logic [7:0] stage_one_q;
	logic [7:0] stage_two_q;

	// ****************************************
	// Two flop crossing
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage_one_q <= RESET_VALUE;
			stage_two_q <= RESET_VALUE;
		end else begin
			stage_one_q <= pins.raw;
			stage_two_q <= stage_one_q;
		end
	end

	assign pins.synced = stage_two_q;

endmodule : pin_synchroniser

// ### logic/pc_card_socket_status_regs.sv
// Function
// - Identification top bits read fixed type code 10b and ignore writes.
// - Identification writable fields change only while subsystem write permit is set.
// - Writing revision 0010b selects the older legacy register compatibility mode.
// - Identification bits 5 and 4 are plain read/write emulation storage.
// - Interface status bit 7 always reads zero.
// - Status bit 6 shows socket power on, from power control; off at reset.
// - Status bit 5 shows the live card ready line.
// - Status bit 4 shows card write protect, 1 means read-only.
// - Status bit 3 is the inverted second card detect pin.
// - Status bit 2 is the inverted first card detect pin.
// - Memory card: bit 1 second battery detect, bit 0 first.
// - I/O card: bit 1 audio output, bit 0 status change output.
// - Upper two status bits zero after reset; lower six follow the pins.
// - Power control bit 7 gates all card output enables; resets to 00h.
// - A memory window with its protect bit set refuses card writes.
// - Card output gate defaults to 0, writing 1 enables outputs.
module pc_card_socket_status_regs
	import socket_regs_pkg::*;
#(
	parameter int WINDOW_COUNT = 5
) (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire logic [5:0]              reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [7:0]              reg_wdata,
	output      logic [7:0]              reg_rdata,
	input  wire logic                    subsystem_write_permit,
	output      logic                    legacy_mode,
	input  wire logic                    card_ready_pin,
	input  wire logic                    card_write_protect_pin,
	input  wire logic                    detect_two_pin_n,
	input  wire logic                    detect_one_pin_n,
	input  wire logic                    battery_detect_two_pin,
	input  wire logic                    battery_detect_one_pin,
	input  wire logic                    card_audio_pin,
	input  wire logic                    card_status_change_pin,
	input  wire logic                    card_is_io,
	input  wire logic                    card_drive_req,
	output      logic                    card_drive_en,
	output      logic                    socket_power_flag,
	output      logic [7:0]              power_control,
	input  wire logic [WINDOW_COUNT-1:0] mem_window_hit,
	input  wire logic [WINDOW_COUNT-1:0] mem_window_protect,
	input  wire logic                    card_write_req,
	output      logic                    card_write_allow
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [1:0] emulation_q;
	logic [3:0] legacy_revision_field_q;
	logic [7:0] power_q;
	logic [7:0] power_d;
	logic [7:0] power_view;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] id_value;
	logic [7:0] status_value;
	logic [7:0] pins_now;
	logic       card_write_protect_flag;
	logic       detect_two_flag;
	logic       detect_one_flag;
	logic [1:0] battery_detect_field;
	logic       id_write;
	logic       power_write;
	logic       sel_id;
	logic       sel_status;
	logic       sel_power;
	logic [7:0] pins_raw;
	logic [WINDOW_COUNT-1:0] window_block;

	pin_sync_if #(.WIDTH(PIN_COUNT)) pins ();

	function automatic logic addr_is(input logic [5:0] a, input logic [5:0] off);
		addr_is = (a == off);
	endfunction : addr_is

	function automatic logic [7:0] write_mask(input logic legacy);
		if (legacy) begin
			write_mask = PWR_LEGACY_MASK;
		end else begin
			write_mask = PWR_NATIVE_MASK;
		end
	endfunction : write_mask

	// ****************************************
	// Pin synchronisation
	// ****************************************
	always_comb begin
		pins_raw                    = PIN_RESET_VALUE;
		pins_raw[PIN_READY]         = card_ready_pin;
		pins_raw[PIN_WP]            = card_write_protect_pin;
		pins_raw[PIN_DETECT_TWO]    = detect_two_pin_n;
		pins_raw[PIN_DETECT_ONE]    = detect_one_pin_n;
		pins_raw[PIN_BATTERY_TWO]   = battery_detect_two_pin;
		pins_raw[PIN_BATTERY_ONE]   = battery_detect_one_pin;
		pins_raw[PIN_AUDIO]         = card_audio_pin;
		pins_raw[PIN_STATUS_CHANGE] = card_status_change_pin;
	end

	assign pins.raw = pins_raw;

	pin_synchroniser #(
		.RESET_VALUE (PIN_RESET_VALUE)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pins     (pins)
	);

	assign pins_now = pins.synced;

	// ****************************************
	// Register select
	// ****************************************
	always_comb begin
		sel_id     = 1'h0;
		sel_status = 1'h0;
		sel_power  = 1'h0;
		if (addr_is(reg_addr, ID_REVISION_OFFSET)) begin
			sel_id = 1'h1;
		end else if (addr_is(reg_addr, INTERFACE_STATUS_OFFSET)) begin
			sel_status = 1'h1;
		end else if (addr_is(reg_addr, POWER_CONTROL_OFFSET)) begin
			sel_power = 1'h1;
		end
	end

	// ****************************************
	// Write decode
	// ****************************************
	// Permit gates identification writes only; power control writes are not gated
	assign id_write    = reg_wr && subsystem_write_permit && sel_id;
	assign power_write = reg_wr && sel_power;

	// ****************************************
	// Identification register
	// ****************************************
	// Emulation storage bits
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			emulation_q <= EMULATION_RESET;
		end else if (id_write) begin
			emulation_q <= reg_wdata[ID_EMU_MSB:ID_EMU_LSB];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			legacy_revision_field_q <= REVISION_RESET;
		end else if (id_write) begin
			legacy_revision_field_q <= reg_wdata[ID_REV_MSB:ID_REV_LSB];
		end
	end

	assign legacy_mode = (legacy_revision_field_q == LEGACY_REVISION_CODE);

	always_comb begin
		id_value                          = 8'h00;
		id_value[ID_TYPE_MSB:ID_TYPE_LSB] = INTERFACE_TYPE_CODE;
		id_value[ID_EMU_MSB:ID_EMU_LSB]   = emulation_q;
		id_value[ID_REV_MSB:ID_REV_LSB]   = legacy_revision_field_q;
	end

	// ****************************************
	// Power control register
	// ****************************************
	always_comb begin
		power_d = power_q;
		if (power_write) begin
			power_d = reg_wdata & write_mask(legacy_mode);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			power_q <= POWER_CONTROL_RESET;
		end else begin
			power_q <= power_d;
		end
	end

	// Reserved bits of the active layout read as zero
	assign power_view    = power_q & write_mask(legacy_mode);
	assign power_control = power_view;

	always_comb begin
		if (legacy_mode) begin
			socket_power_flag = power_view[PWR_VCC_EN_BIT];
		end else begin
			socket_power_flag = (power_view[PWR_VCC_MSB:PWR_VCC_LSB] != VCC_OFF) &&
			                    (power_view[PWR_VCC_MSB:PWR_VCC_LSB] != VCC_OFF_RESERVED);
		end
	end

	assign card_drive_en = card_drive_req && power_view[PWR_GATE_BIT];

	// ****************************************
	// Window write protection
	// ****************************************
	genvar w;
	generate
		for (w = 0; w < WINDOW_COUNT; w++) begin : g_window
			assign window_block[w] = mem_window_hit[w] && mem_window_protect[w];
		end
	endgenerate

	assign card_write_allow = card_write_req && !(|window_block);

	// ****************************************
	// Interface status
	// ****************************************
	// Write protect
	assign card_write_protect_flag = pins_now[PIN_WP];
	assign detect_two_flag = !pins_now[PIN_DETECT_TWO];
	assign detect_one_flag = !pins_now[PIN_DETECT_ONE];

	always_comb begin
		if (card_is_io) begin
			battery_detect_field = {pins_now[PIN_AUDIO], pins_now[PIN_STATUS_CHANGE]};
		end else begin
			battery_detect_field = {pins_now[PIN_BATTERY_TWO], pins_now[PIN_BATTERY_ONE]};
		end
	end

	always_comb begin
		status_value                      = 8'h00;
		status_value[STAT_POWER_BIT]      = socket_power_flag;
		status_value[STAT_READY_BIT]      = pins_now[PIN_READY];
		status_value[STAT_WP_BIT]         = card_write_protect_flag;
		status_value[STAT_DETECT_TWO_BIT] = detect_two_flag;
		status_value[STAT_DETECT_ONE_BIT] = detect_one_flag;
		status_value[1:0]                 = battery_detect_field;
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			if (sel_id) begin
				rdata_d = id_value;
			end else if (sel_status) begin
				rdata_d = status_value;
			end else if (sel_power) begin
				rdata_d = power_view;
			end else begin
				rdata_d = READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_q <= READ_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : pc_card_socket_status_regs

// ### tb/socket_regs_checker.sv
module socket_regs_checker
	import socket_regs_pkg::*;
#(
	parameter int WINDOW_COUNT = 5
) (
	input wire logic					core_clk,
	input wire logic					rst_n,
	input wire logic [5:0]				reg_addr,
	input wire logic					reg_wr,
	input wire logic					reg_rd,
	input wire logic [7:0]				reg_wdata,
	input wire logic [7:0]				reg_rdata,
	input wire logic					subsystem_write_permit,
	input wire logic					legacy_mode,
	input wire logic					card_ready_pin,
	input wire logic					card_write_protect_pin,
	input wire logic					detect_two_pin_n,
	input wire logic					detect_one_pin_n,
	input wire logic					battery_detect_two_pin,
	input wire logic					battery_detect_one_pin,
	input wire logic					card_audio_pin,
	input wire logic					card_status_change_pin,
	input wire logic					card_is_io,
	input wire logic					card_drive_req,
	input wire logic					card_drive_en,
	input wire logic					socket_power_flag,
	input wire logic [7:0]				power_control,
	input wire logic [WINDOW_COUNT-1:0]	mem_window_hit,
	input wire logic [WINDOW_COUNT-1:0]	mem_window_protect,
	input wire logic					card_write_req,
	input wire logic					card_write_allow
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Helpers and assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic			rd_st = reg_rd && reg_addr == INTERFACE_STATUS_OFFSET;
	wire logic			id_wr = reg_wr && reg_addr == ID_REVISION_OFFSET && subsystem_write_permit;
	wire logic			rev_two = reg_wdata[3:0] == LEGACY_REVISION_CODE;
	wire logic [3:0]	pins_now = {card_ready_pin, card_write_protect_pin, ~detect_two_pin_n,
		~detect_one_pin_n};
	wire logic [7:0]	pwr_next = reg_wdata & (legacy_mode ? PWR_LEGACY_MASK : PWR_NATIVE_MASK);
	property p_type; reg_rd && reg_addr == ID_REVISION_OFFSET |=> reg_rdata[7:6] == 2'h2; endproperty
	a_type: assert property (p_type) else $error("id type bits wrong");
	property p_msb; rd_st |=> !reg_rdata[7]; endproperty
	a_msb: assert property (p_msb) else $error("status bit 7 set");
	property p_pwr_read; rd_st |=> reg_rdata[6] == $past(socket_power_flag); endproperty
	a_pwr_read: assert property (p_pwr_read) else $error("status power bit wrong");
	property p_pins; rd_st |=> reg_rdata[5:2] == $past(pins_now, 3); endproperty
	a_pins: assert property (p_pins) else $error("status pin bits wrong");
	property p_low; rd_st |=> reg_rdata[1:0] == ($past(card_is_io) ?
		$past({card_audio_pin, card_status_change_pin}, 3) :
		$past({battery_detect_two_pin, battery_detect_one_pin}, 3)); endproperty
	a_low: assert property (p_low) else $error("status low bits wrong");
	property p_legacy; id_wr |=> legacy_mode == $past(rev_two); endproperty
	a_legacy: assert property (p_legacy) else $error("legacy mode wrong");
	property p_pwr_wr; reg_wr && reg_addr == POWER_CONTROL_OFFSET |=> power_control == $past(pwr_next);
	endproperty
	a_pwr_wr: assert property (p_pwr_wr) else $error("power write wrong");
	property p_gate; card_drive_en == (card_drive_req && power_control[PWR_GATE_BIT]); endproperty
	a_gate: assert property (p_gate) else $error("output gate wrong");
	property p_allow; card_write_allow == (card_write_req && !(|(mem_window_hit & mem_window_protect)));
	endproperty
	a_allow: assert property (p_allow) else $error("window protect wrong");
	property p_lock; reg_wr && reg_addr == ID_REVISION_OFFSET && !subsystem_write_permit |=>
		$stable(legacy_mode); endproperty
	a_lock: assert property (p_lock) else $error("locked id write took effect");
	property p_pwr_rsvd; reg_rd && reg_addr == POWER_CONTROL_OFFSET |=> (reg_rdata &
		~($past(legacy_mode) ? PWR_LEGACY_MASK : PWR_NATIVE_MASK)) == 8'h00; endproperty
	a_pwr_rsvd: assert property (p_pwr_rsvd) else $error("power reserved bits set");
	c_legacy: cover property (id_wr && rev_two);
	c_io: cover property (rd_st && card_is_io);
	c_deny: cover property (card_write_req && !card_write_allow);
endmodule : socket_regs_checker

bind pc_card_socket_status_regs socket_regs_checker #(.WINDOW_COUNT(WINDOW_COUNT)) i_socket_regs_checker (.*);

// ### tb/card_model.sv
module card_model
	import socket_regs_pkg::*;
(
	input wire logic				core_clk,
	input wire logic				inserted,
	input wire logic [5:0]			lines,
	output logic [PIN_COUNT-1:0]	pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Socket pins
	// ****************************************
	// Empty socket: detects pulled high, other lines pulled low
	always_ff @(posedge core_clk) begin
		pins <= inserted ? {lines[5:2], 2'h0, lines[1:0]} : PIN_RESET_VALUE;
	end
endmodule : card_model

// ### tb/pc_card_socket_status_regs_tb.sv
module pc_card_socket_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import socket_regs_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic		core_clk = 1'h0;
	logic		rst_n = 1'h0;
	logic [5:0]	reg_addr = 6'h00;
	logic		reg_wr = 1'h0;
	logic		reg_rd = 1'h0;
	logic [7:0]	reg_wdata = 8'h00;
	logic		permit = 1'h0;
	logic		card_in = 1'h0;
	logic		is_io = 1'h0;
	logic [5:0]	lines = 6'h00;
	logic		drv_req = 1'h0;
	logic		wr_req = 1'h0;
	logic [4:0]	hit = 5'h00;
	logic [4:0]	prot = 5'h00;
	logic [7:0]	pins, reg_rdata, power_control, exp_id, exp_pwr, got, d;
	logic		legacy_mode, card_drive_en, socket_power_flag, card_write_allow;
	logic [31:0]	r;
	int			mismatches = 0;
	int			n_compared = 0;
	int			cycles = 0;
	card_model i_card_model (.core_clk(core_clk), .inserted(card_in), .lines(lines), .pins(pins));
	pc_card_socket_status_regs #(.WINDOW_COUNT(5)) i_pc_card_socket_status_regs (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.subsystem_write_permit(permit), .legacy_mode(legacy_mode),
		.card_ready_pin(pins[0]), .card_write_protect_pin(pins[1]), .detect_two_pin_n(pins[2]),
		.detect_one_pin_n(pins[3]), .battery_detect_two_pin(pins[4]),
		.battery_detect_one_pin(pins[5]), .card_audio_pin(pins[6]),
		.card_status_change_pin(pins[7]), .card_is_io(is_io), .card_drive_req(drv_req),
		.card_drive_en(card_drive_en), .socket_power_flag(socket_power_flag),
		.power_control(power_control), .mem_window_hit(hit), .mem_window_protect(prot),
		.card_write_req(wr_req), .card_write_allow(card_write_allow));
	always #50 core_clk = ~core_clk;
	// ****************************************
	// Tasks
	// ****************************************
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(logic [5:0] a, logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rchk(string what, logic [5:0] a, logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(negedge core_clk);
		chk(what, e, reg_rdata);
	endtask : rchk
	function automatic logic [7:0] exp_status(logic pw, logic io, logic [7:0] p);
		return {1'h0, pw, p[0], p[1], ~p[2], ~p[3], io ? {p[6], p[7]} : {p[4], p[5]}};
	endfunction : exp_status
	task automatic after_reset();
		exp_id = {INTERFACE_TYPE_CODE, EMULATION_RESET, REVISION_RESET};
		exp_pwr = POWER_CONTROL_RESET;
		rchk("id reset", ID_REVISION_OFFSET, exp_id);
		rchk("power reset", POWER_CONTROL_OFFSET, exp_pwr);
		rchk("status reset", INTERFACE_STATUS_OFFSET, exp_status(1'h0, is_io, pins));
		chk("gate reset", 8'h00, {7'h0, card_drive_en});
	endtask : after_reset
	// ****************************************
	// Sequence
	// ****************************************
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(41));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'h1;
		after_reset();
		rchk("unmapped", 6'h3F, 8'h00);
		wr(6'h00, 8'h72);
		rchk("id locked", 6'h00, exp_id);
		@(posedge core_clk);
		permit <= 1'h1;
		for (int i = 0; i < 30; i++) begin
			r = $urandom;
			d = (i == 0) ? 8'h72 : (r[20] ? 8'h02 : r[31:24]);
			if (i % 3 == 0) begin
				wr(6'h00, d);
				exp_id = {2'h2, d[5:0]};
				rchk("id", 6'h00, exp_id);
				chk("legacy", {7'h0, exp_id[3:0] == 4'h2}, {7'h0, legacy_mode});
				exp_pwr = exp_pwr & ((exp_id[3:0] == 4'h2) ? 8'hB3 : 8'h9B);
				rchk("power view", 6'h02, exp_pwr);
			end
			d = (i == 1) ? 8'hFF : r[29:22];
			wr(6'h01, ~d);
			wr(6'h02, d);
			exp_pwr = d & ((exp_id[3:0] == 4'h2) ? 8'hB3 : 8'h9B);
			rchk("power", 6'h02, exp_pwr);
			chk("power port", exp_pwr, power_control);
			chk("power flag", {7'h0, exp_pwr[4]}, {7'h0, socket_power_flag});
			@(posedge core_clk);
			card_in <= r[0];
			is_io <= r[1];
			drv_req <= r[2];
			wr_req <= r[3];
			lines <= r[9:4];
			hit <= r[14:10];
			prot <= r[19:15];
			repeat (4) @(posedge core_clk);
			chk("drive", {7'h0, drv_req & exp_pwr[7]}, {7'h0, card_drive_en});
			chk("allow", {7'h0, wr_req & ~|(hit & prot)}, {7'h0, card_write_allow});
			rchk("status", 6'h01, exp_status(exp_pwr[4], is_io, pins));
		end
		@(posedge core_clk);
		card_in <= 1'h0;
		rst_n <= 1'h0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'h1;
		after_reset();
		report_and_stop();
	end
endmodule : pc_card_socket_status_regs_tb
